// File: hw/embedded_ram_blocks.sv
`timescale 1ns/1ps
`include "ram_blocks_cfg.svh"

// What this block does
// [R1] Small block: 576 bits, no true dual-port
// [R2] Small and medium contents preloadable before use
// [R3] Small write registers share one clock
// [R4] Small read side may use either clock
// [R5] Only the output register may be bypassed
// [R6] Small controls driven by clocks or logic
// [R7] Medium block: 4,608 bits, true dual-port
// [R8] Medium/large port registers on either clock
// [R9] Medium/large have independent A and B ports
// [R10] Large block: 589,824 bits, no ROM/shift
// [R11] Large block: no preload, contents undefined
// [R12] Large block synchronous, all inputs registered; the code clears the port outputs asynchronously
// [R13] Large port: 16-bit address, 72-bit data, lanes
// [R14] Disabled byte lanes keep stored bytes
module embedded_ram_blocks
    import ram_blocks_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic clk1_en_in,
    input wire logic sm_rden_in,
    input wire logic [`SM_AW-1:0] sm_rd_addr_in,
    input wire logic sm_clr_in,
    output logic [`SM_DW-1:0] sm_q_out,
    input wire logic md_b_clken_in,
    input wire logic md_b_we_in,
    input wire logic [`MD_AW-1:0] md_b_addr_in,
    input wire logic md_b_addr_ena_in,
    input wire logic [`MD_NB-1:0] md_b_be_in,
    input wire logic [`MD_DW-1:0] md_b_din_in,
    input wire logic md_b_clr_in,
    output logic [`MD_DW-1:0] md_b_q_out,
    input wire logic lg_a_clken_in,
    input wire logic lg_a_we_in,
    input wire logic [`LG_PAW-1:0] lg_a_addr_in,
    input wire logic lg_a_addr_ena_in,
    input wire logic [`LG_NB-1:0] lg_a_be_in,
    input wire logic [`LG_DW-1:0] lg_a_din_in,
    input wire logic lg_a_clr_in,
    output logic [`LG_DW-1:0] lg_a_q_out,
    input wire logic lg_b_clken_in,
    input wire logic lg_b_we_in,
    input wire logic [`LG_PAW-1:0] lg_b_addr_in,
    input wire logic lg_b_addr_ena_in,
    input wire logic [`LG_NB-1:0] lg_b_be_in,
    input wire logic [`LG_DW-1:0] lg_b_din_in,
    input wire logic lg_b_clr_in,
    output logic [`LG_DW-1:0] lg_b_q_out
);
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    // Clock 0 ticks every edge, clock 1 when its enable is high
    function automatic logic tick(input logic sel, input logic c1);
        return sel ? c1 : 1'b1;
    endfunction

    // Byte-lane merge of a bus write into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    bus_state_type st_r;
    logic [`CFG_W-1:0] cfg_r;
    logic [`ADDR_W-1:0] addr_r;
    logic [31:0] wlo_r, rlo_r, rd_val, wmerge;
    logic [3:0] whi_r, rhi_r, cmd_be_r;
    logic cmd_we_r, cmd_md_r, coll_r, ack_r;
    logic req, wr_hit, cmd_go, coll_set, coll_clr;
    logic act, a_tick, sm_a_en, md_a_en, sm_b_en, md_b_en;
    logic md_b_we, lg_a_en, lg_b_en, lg_a_wr, lg_b_wr;
    logic [`MD_DW-1:0] md_qa;

    // Bus handshake: ack one cycle after request, write lands with ack
    assign req = wb_cyc_in && wb_stb_in;
    assign wr_hit = req && wb_we_in && ack_r;
    assign cmd_go = wr_hit && wb_adr_in == `OFS_CMD && wb_sel_in[0]
                    && wb_dat_in[`CMD_GO] && st_r == ST_IDLE;
    assign coll_clr = wr_hit && wb_adr_in == `OFS_STAT && wb_sel_in[0]
                      && wb_dat_in[`ST_COLL];

    // Bus answer registers
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_r <= 1'b0;
            wb_dat_out <= '0;
        end else begin
            ack_r <= req && !ack_r;
            if (req && !ack_r && !wb_we_in) wb_dat_out <= rd_val;
        end
    end
    assign wb_ack_out = ack_r;

    // Register read decode, unmapped reads answer zero
    always_comb begin
        rd_val = '0;
        case (wb_adr_in)
            `OFS_CFG: rd_val = 32'(cfg_r);
            `OFS_ADDR: rd_val = 32'(addr_r);
            `OFS_WLO: rd_val = wlo_r;
            `OFS_WHI: rd_val = 32'(whi_r);
            `OFS_STAT: begin
                rd_val[`ST_BUSY] = st_r != ST_IDLE;
                rd_val[`ST_COLL] = coll_r;
            end
            `OFS_RLO: rd_val = rlo_r;
            `OFS_RHI: rd_val = 32'(rhi_r);
            default: rd_val = '0;
        endcase
    end

    // Bus data merged into the addressed register
    assign wmerge = merge(rd_val, wb_dat_in, wb_sel_in);

    // Software-written configuration and data staging
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_r <= `CFG_RST;
            addr_r <= '0;
            wlo_r <= '0;
            whi_r <= '0;
        end else if (wr_hit) begin
            case (wb_adr_in)
                `OFS_CFG: cfg_r <= wmerge[`CFG_W-1:0];
                `OFS_ADDR: addr_r <= wmerge[`ADDR_W-1:0];
                `OFS_WLO: wlo_r <= wmerge;
                `OFS_WHI: whi_r <= wmerge[3:0];
                default: ;
            endcase
        end
    end

    // Bus port A strobes follow the selected clock of the target block
    assign act = st_r == ST_ISSUE || st_r == ST_FLUSH;
    assign a_tick = cmd_md_r ? tick(cfg_r[`CFG_MD_A_SEL], clk1_en_in)
                             : tick(cfg_r[`CFG_SM_WR_SEL], clk1_en_in); // [R3] [R8]
    assign sm_a_en = act && !cmd_md_r && a_tick; // [R3]
    assign md_a_en = act && cmd_md_r && a_tick;

    // Command sequencer: write or read, then one flush tick, then capture
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= ST_IDLE;
            cmd_we_r <= 1'b0;
            cmd_md_r <= 1'b0;
            cmd_be_r <= '0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    if (cmd_go) begin
                        st_r <= ST_ISSUE;
                        cmd_we_r <= wb_dat_in[`CMD_WR];
                        cmd_be_r <= wb_dat_in[`CMD_BE +: 4];
                        cmd_md_r <= addr_r[`ADDR_BLK];
                    end
                end
                ST_ISSUE: if (a_tick) st_r <= ST_FLUSH;
                ST_FLUSH: if (a_tick) st_r <= ST_DONE;
                ST_DONE: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Read-back capture; the small block has no bus read path
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rlo_r <= '0;
            rhi_r <= '0;
        end else if (st_r == ST_DONE) begin
            rlo_r <= cmd_md_r ? md_qa[31:0] : '0;
            rhi_r <= cmd_md_r ? md_qa[35:32] : '0;
        end
    end

    // Large-block same-word write clash, set wins over clear
    assign lg_a_wr = lg_a_en && lg_a_we_in;
    assign lg_b_wr = lg_b_en && lg_b_we_in;
    assign coll_set = lg_a_wr && lg_b_wr
                      && lg_a_addr_in[`LG_AW-1:0] == lg_b_addr_in[`LG_AW-1:0];
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            coll_r <= 1'b0;
        end else begin
            coll_r <= coll_set || (coll_r && !coll_clr);
        end
    end

    // User port enables from per-port clock choice and clock enable
    assign sm_b_en = sm_rden_in && tick(cfg_r[`CFG_SM_RD_SEL], clk1_en_in); // [R4] [R6]
    assign md_b_en = md_b_clken_in && tick(cfg_r[`CFG_MD_B_SEL], clk1_en_in); // [R8] [R9]
    assign md_b_we = md_b_we_in && !cfg_r[`CFG_MD_ROM]; // [R2]
    assign lg_a_en = lg_a_clken_in && tick(cfg_r[`CFG_LG_A_SEL], clk1_en_in); // [R8]
    assign lg_b_en = lg_b_clken_in && tick(cfg_r[`CFG_LG_B_SEL], clk1_en_in); // [R9]

    // Small block: write-only port A from bus, read-only port B to user
    ram_core #(.AW(`SM_AW), .DW(`SM_DW), .NB(`SM_NB), .TDP(0)) u_small ( // [R1]
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .a_en_in(sm_a_en),
        .a_we_in(st_r == ST_ISSUE && cmd_we_r), // [R2]
        .a_addr_in(addr_r[`SM_AW-1:0]),
        .a_addr_ena_in(sm_a_en),
        .a_be_in(cmd_be_r[`SM_NB-1:0]),
        .a_din_in(wlo_r[`SM_DW-1:0]),
        .a_byp_in(1'b0),
        .a_clr_in(sm_clr_in),
        .a_q_out(),
        .b_en_in(sm_b_en),
        .b_we_in(1'b0),
        .b_addr_in(sm_rd_addr_in),
        .b_addr_ena_in(sm_rden_in),
        .b_be_in('0),
        .b_din_in('0),
        .b_byp_in(cfg_r[`CFG_SM_BYP]), // [R5]
        .b_clr_in(sm_clr_in), // [R6]
        .b_q_out(sm_q_out)
    );

    // Medium block: port A on the bus for preload, port B to user
    ram_core #(.AW(`MD_AW), .DW(`MD_DW), .NB(`MD_NB), .TDP(1)) u_medium ( // [R7]
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .a_en_in(md_a_en),
        .a_we_in(st_r == ST_ISSUE && cmd_we_r), // [R2]
        .a_addr_in(addr_r[`MD_AW-1:0]),
        .a_addr_ena_in(md_a_en),
        .a_be_in(cmd_be_r),
        .a_din_in({whi_r, wlo_r}),
        .a_byp_in(cfg_r[`CFG_MD_A_BYP]),
        .a_clr_in(1'b0),
        .a_q_out(md_qa),
        .b_en_in(md_b_en),
        .b_we_in(md_b_we),
        .b_addr_in(md_b_addr_in),
        .b_addr_ena_in(md_b_addr_ena_in),
        .b_be_in(md_b_be_in),
        .b_din_in(md_b_din_in),
        .b_byp_in(cfg_r[`CFG_MD_B_BYP]), // [R5]
        .b_clr_in(md_b_clr_in),
        .b_q_out(md_b_q_out)
    );

    // Large block: both ports to user, no bus load path
    ram_core #(.AW(`LG_AW), .DW(`LG_DW), .NB(`LG_NB), .TDP(1)) u_large ( // [R10] [R11]
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .a_en_in(lg_a_en), // [R12]
        .a_we_in(lg_a_we_in),
        .a_addr_in(lg_a_addr_in[`LG_AW-1:0]), // [R13]
        .a_addr_ena_in(lg_a_addr_ena_in),
        .a_be_in(lg_a_be_in),
        .a_din_in(lg_a_din_in),
        .a_byp_in(cfg_r[`CFG_LG_A_BYP]),
        .a_clr_in(lg_a_clr_in),
        .a_q_out(lg_a_q_out),
        .b_en_in(lg_b_en), // [R12]
        .b_we_in(lg_b_we_in),
        .b_addr_in(lg_b_addr_in[`LG_AW-1:0]), // [R13]
        .b_addr_ena_in(lg_b_addr_ena_in),
        .b_be_in(lg_b_be_in),
        .b_din_in(lg_b_din_in),
        .b_byp_in(cfg_r[`CFG_LG_B_BYP]),
        .b_clr_in(lg_b_clr_in),
        .b_q_out(lg_b_q_out)
    );

    // Command steps
    sequence issue_s;
        st_r == ST_ISSUE && a_tick;
    endsequence

    sequence flush_s;
        st_r == ST_FLUSH && a_tick;
    endsequence

    property cmd_done_p;
        issue_s ##1 flush_s |=> st_r == ST_DONE ##1 st_r == ST_IDLE;
    endproperty

    // Bus timing
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus ack held longer than one cycle");

    ack_time_a: assert property (req && !wb_ack_out |=> wb_ack_out)
        else $error("bus ack not one cycle after request");

    // Sequencer
    cmd_step_a: assert property (issue_s |=> st_r == ST_FLUSH) // [R3]
        else $error("command did not advance on its clock tick");

    cmd_done_a: assert property (cmd_done_p) // [R8]
        else $error("command did not finish after flush tick");

    rdata_take_a: assert property ( // [R7]
        st_r == ST_DONE && cmd_md_r |=> rlo_r == $past(md_qa[31:0]))
        else $error("read-back not taken from medium port A");

    // Output registers and medium ROM-mode write lock
    sm_hold_a: assert property ( // [R4]
        !sm_b_en && !sm_clr_in ##1 !sm_clr_in |-> $stable(sm_q_out))
        else $error("small output moved without read tick");

    lg_hold_a: assert property ( // [R12]
        !lg_a_en && !lg_a_clr_in ##1 !lg_a_clr_in |-> $stable(lg_a_q_out))
        else $error("large port A output moved without tick");

    lg_clear_a: assert property (lg_b_clr_in |-> lg_b_q_out == '0) // [R12]
        else $error("large port B output not cleared");

    rom_lock_a: assert property ( // [R2]
        cfg_r[`CFG_MD_ROM] && md_b_we_in |-> !md_b_we)
        else $error("user write reached medium block in ROM mode");

    // Clash flag
    coll_set_a: assert property (coll_set |=> coll_r) // [R9]
        else $error("write clash flag not set");

    coll_keep_a: assert property (coll_r && !coll_clr |=> coll_r)
        else $error("write clash flag dropped without clear");
endmodule

// File: hw/ram_blocks_cfg.svh
`ifndef RAM_BLOCKS_CFG_SVH
`define RAM_BLOCKS_CFG_SVH
// Block geometry: address bits, data bits, byte lanes
`define SM_AW 5
`define SM_DW 18
`define SM_NB 2
`define MD_AW 7
`define MD_DW 36
`define MD_NB 4
`define LG_AW 13
`define LG_PAW 16
`define LG_DW 72
`define LG_NB 8
// Register byte offsets
`define OFS_CFG 8'h00
`define OFS_ADDR 8'h04
`define OFS_WLO 8'h08
`define OFS_WHI 8'h0C
`define OFS_CMD 8'h10
`define OFS_STAT 8'h14
`define OFS_RLO 8'h18
`define OFS_RHI 8'h1C
// Configuration fields and reset value
`define CFG_SM_BYP 0
`define CFG_SM_WR_SEL 1
`define CFG_SM_RD_SEL 2
`define CFG_MD_A_SEL 3
`define CFG_MD_B_SEL 4
`define CFG_LG_A_SEL 5
`define CFG_LG_B_SEL 6
`define CFG_MD_A_BYP 7
`define CFG_MD_B_BYP 8
`define CFG_LG_A_BYP 9
`define CFG_LG_B_BYP 10
`define CFG_MD_ROM 11
`define CFG_W 12
`define CFG_RST 12'h000
// Address register fields
`define ADDR_BLK 8
`define ADDR_W 9
// Command and status fields
`define CMD_GO 0
`define CMD_WR 1
`define CMD_BE 4
`define ST_BUSY 0
`define ST_COLL 1
`endif

// File: hw/ram_blocks_pkg.sv
package ram_blocks_pkg;
    // Bus-side memory command sequencer
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_FLUSH = 4'b0100,
        ST_DONE = 4'b1000
    } bus_state_type;
endpackage

// File: hw/ram_core.sv
`timescale 1ns/1ps
module ram_core #(
    parameter int AW = 5,
    parameter int DW = 18,
    parameter int NB = 2,
    parameter int TDP = 0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic a_en_in,
    input wire logic a_we_in,
    input wire logic [AW-1:0] a_addr_in,
    input wire logic a_addr_ena_in,
    input wire logic [NB-1:0] a_be_in,
    input wire logic [DW-1:0] a_din_in,
    input wire logic a_byp_in,
    input wire logic a_clr_in,
    output logic [DW-1:0] a_q_out,
    input wire logic b_en_in,
    input wire logic b_we_in,
    input wire logic [AW-1:0] b_addr_in,
    input wire logic b_addr_ena_in,
    input wire logic [NB-1:0] b_be_in,
    input wire logic [DW-1:0] b_din_in,
    input wire logic b_byp_in,
    input wire logic b_clr_in,
    output logic [DW-1:0] b_q_out
);
    localparam int LW = DW / NB;
    localparam int DEPTH = 1 << AW;

    // Storage array, never reset
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] a_addr_r, b_addr_r, a_eff, b_eff;
    logic [DW-1:0] a_rd_r, b_rd_r;

    // Address hold: low keeps last latched address
    assign a_eff = a_addr_ena_in ? a_addr_in : a_addr_r;
    assign b_eff = b_addr_ena_in ? b_addr_in : b_addr_r;

    // Address registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            a_addr_r <= '0;
            b_addr_r <= '0;
        end else begin
            if (a_en_in && a_addr_ena_in) a_addr_r <= a_addr_in;
            if (b_en_in && b_addr_ena_in) b_addr_r <= b_addr_in;
        end
    end

    // Lane-masked writes, port B wins a same-word clash
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < NB; i++) begin
            if (a_en_in && a_we_in && a_be_in[i]) begin
                mem[a_eff][i*LW +: LW] <= a_din_in[i*LW +: LW]; // [R14]
            end
            if (TDP != 0 && b_en_in && b_we_in && b_be_in[i]) begin
                mem[b_eff][i*LW +: LW] <= b_din_in[i*LW +: LW]; // [R14]
            end
        end
    end

    // Registered read, old data on read-during-write
    always_ff @(posedge clk_in) begin
        if (a_en_in) a_rd_r <= mem[a_eff];
        if (b_en_in) b_rd_r <= mem[b_eff];
    end

    // Port A output register, bypass takes read stage
    always_ff @(posedge clk_in or negedge rstn_in or posedge a_clr_in) begin
        if (!rstn_in) begin
            a_q_out <= '0;
        end else if (a_clr_in) begin
            a_q_out <= '0;
        end else if (a_en_in) begin
            a_q_out <= a_byp_in ? mem[a_eff] : a_rd_r; // [R5]
        end
    end

    // Port B output register
    always_ff @(posedge clk_in or negedge rstn_in or posedge b_clr_in) begin
        if (!rstn_in) begin
            b_q_out <= '0;
        end else if (b_clr_in) begin
            b_q_out <= '0;
        end else if (b_en_in) begin
            b_q_out <= b_byp_in ? mem[b_eff] : b_rd_r; // [R5]
        end
    end
endmodule

// File: test/port_user.sv
`timescale 1ns/1ps
// User logic in a neighbouring logic row driving one memory port
module port_user #(
    parameter int AW = 16,
    parameter int DW = 72,
    parameter int NB = 8
) (
    input wire logic clk_in,
    input wire logic byp_in,
    output logic en_out,
    output logic we_out,
    output logic [AW-1:0] addr_out,
    output logic addr_ena_out,
    output logic [NB-1:0] be_out,
    output logic [DW-1:0] din_out,
    output logic clr_out,
    output logic pv_out
);
    // Quiet port at time zero
    initial begin
        en_out = 1'b0;
        we_out = 1'b0;
        addr_out = '0;
        addr_ena_out = 1'b1;
        be_out = '0;
        din_out = '0;
        clr_out = 1'b0;
        pv_out = 1'b0;
    end

    // Idle gap, one access, then pv_out marks the cycle when q is due
    task automatic access(input int gap, input logic w, input logic [AW-1:0] a,
                          input logic [NB-1:0] b, input logic [DW-1:0] d);
        repeat (gap) begin
            @(posedge clk_in);
            din_out <= ~din_out; // Released data keeps moving
        end
        @(posedge clk_in);
        en_out <= 1'b1;
        we_out <= w;
        addr_out <= a;
        be_out <= b;
        din_out <= d;
        @(posedge clk_in);
        if (!w && !byp_in) begin
            @(posedge clk_in); // Registered output needs a second enabled edge
        end
        en_out <= 1'b0;
        we_out <= 1'b0;
        addr_out <= ~a;
        pv_out <= !w;
        @(posedge clk_in);
        pv_out <= 1'b0;
    endtask

    // Pulse the asynchronous clear, then mark q as due
    task automatic clear();
        @(posedge clk_in);
        clr_out <= 1'b1;
        @(posedge clk_in);
        clr_out <= 1'b0;
        pv_out <= 1'b1;
        @(posedge clk_in);
        pv_out <= 1'b0;
    endtask
endmodule

// File: test/embedded_ram_blocks_tb.sv
`timescale 1ns/1ps
`include "ram_blocks_cfg.svh"
module embedded_ram_blocks_tb;
    typedef struct {
        int id;
        logic [71:0] v;
    } note_type;
    note_type exp_q[$];
    int miscompares = 0;
    int checks_done = 0;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, rd_chk = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, r;
    logic wb_ack_out, clk1_en_in = 1'b1, sm_rden_in = 1'b0, sm_clr_in = 1'b0, sm_pv = 1'b0;
    logic [4:0] sm_rd_addr_in = 5'h00;
    logic [17:0] sm_q_out;
    logic [11:0] cfg_v = 12'h000;
    logic m_en, m_we, m_ae, m_clr, m_pv, a_en, a_we, a_ae, a_clr, a_pv;
    logic b_en, b_we, b_ae, b_clr, b_pv;
    logic [6:0] m_addr;
    logic [3:0] m_be;
    logic [35:0] m_din, m_q;
    logic [15:0] a_addr, b_addr;
    logic [7:0] a_be, b_be;
    logic [71:0] a_din, b_din, a_q, b_q;
    logic [71:0] lg_m [int];
    logic [15:0] pool [4];

    // 20 MHz clock
    always #25 sys_clk_in = ~sys_clk_in;

    embedded_ram_blocks dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .clk1_en_in(clk1_en_in),
        .sm_rden_in(sm_rden_in), .sm_rd_addr_in(sm_rd_addr_in), .sm_clr_in(sm_clr_in),
        .sm_q_out(sm_q_out), .md_b_clken_in(m_en), .md_b_we_in(m_we),
        .md_b_addr_in(m_addr), .md_b_addr_ena_in(m_ae), .md_b_be_in(m_be),
        .md_b_din_in(m_din), .md_b_clr_in(m_clr), .md_b_q_out(m_q),
        .lg_a_clken_in(a_en), .lg_a_we_in(a_we), .lg_a_addr_in(a_addr),
        .lg_a_addr_ena_in(a_ae), .lg_a_be_in(a_be), .lg_a_din_in(a_din),
        .lg_a_clr_in(a_clr), .lg_a_q_out(a_q), .lg_b_clken_in(b_en), .lg_b_we_in(b_we),
        .lg_b_addr_in(b_addr), .lg_b_addr_ena_in(b_ae), .lg_b_be_in(b_be),
        .lg_b_din_in(b_din), .lg_b_clr_in(b_clr), .lg_b_q_out(b_q));

    port_user #(.AW(16), .DW(72), .NB(8)) u_a (.clk_in(sys_clk_in), .byp_in(cfg_v[9]),
        .en_out(a_en), .we_out(a_we), .addr_out(a_addr), .addr_ena_out(a_ae),
        .be_out(a_be), .din_out(a_din), .clr_out(a_clr), .pv_out(a_pv));
    port_user #(.AW(16), .DW(72), .NB(8)) u_b (.clk_in(sys_clk_in), .byp_in(cfg_v[10]),
        .en_out(b_en), .we_out(b_we), .addr_out(b_addr), .addr_ena_out(b_ae),
        .be_out(b_be), .din_out(b_din), .clr_out(b_clr), .pv_out(b_pv));
    port_user #(.AW(7), .DW(36), .NB(4)) u_m (.clk_in(sys_clk_in), .byp_in(cfg_v[8]),
        .en_out(m_en), .we_out(m_we), .addr_out(m_addr), .addr_ena_out(m_ae),
        .be_out(m_be), .din_out(m_din), .clr_out(m_clr), .pv_out(m_pv));

    // Compare a seen result with the oldest note
    task automatic check(input int id, input logic [71:0] seen);
        note_type n;
        checks_done++;
        n = (exp_q.size() > 0) ? exp_q.pop_front() : note_type'{-1, 72'h0};
        if (n.id != id || n.v !== seen) begin
            miscompares++;
            $display("MISMATCH result %0d expected %h seen %h", id, n.v, seen);
        end
    endtask

    // Watcher takes a note whenever a result is due
    always @(posedge sys_clk_in) begin
        if (a_pv) check(0, a_q);
        if (b_pv) check(1, b_q);
        if (m_pv) check(2, {36'h0, m_q});
        if (sm_pv) check(3, {54'h0, sm_q_out});
        if (wb_ack_out === 1'b1 && rd_chk) check(4, {40'h0, wb_dat_out});
    end

    task automatic note(input int id, input logic [71:0] v);
        exp_q.push_back('{id, v});
    endtask

    function automatic logic [71:0] merge(logic [71:0] o, logic [71:0] d, logic [7:0] be);
        for (int i = 0; i < 8; i++) begin
            if (be[i]) o[9*i +: 9] = d[9*i +: 9];
        end
        return o;
    endfunction

    function automatic logic [71:0] rnd72();
        return 72'({$urandom, $urandom, $urandom});
    endfunction

    // One classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic c);
        int n;
        @(posedge sys_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        wb_sel_in <= s;
        rd_chk <= c;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 20);
        r = wb_dat_out;
        if (n >= 20) miscompares++;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        rd_chk <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        note(4, {40'h0, e});
        wb(1'b0, a, 32'h0, 4'hF, 1'b1);
    endtask

    task automatic setcfg(input logic [11:0] v);
        wr(`OFS_CFG, {20'h0, v});
        cfg_v = v;
    endtask

    // Memory command through the registers, then poll busy
    task automatic mem_op(input logic blk, input logic [6:0] wd, input logic w,
                          input logic [3:0] be, input logic [35:0] d);
        int n;
        wr(`OFS_ADDR, {23'h0, blk, 1'b0, wd});
        wr(`OFS_WLO, d[31:0]);
        wr(`OFS_WHI, {28'h0, d[35:32]});
        wr(`OFS_CMD, {24'h0, be, 2'b00, w, 1'b1});
        n = 0;
        do begin
            wb(1'b0, `OFS_STAT, 32'h0, 4'hF, 1'b0);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (r[0] !== 1'b0) miscompares++;
    endtask

    task automatic lg_acc(input logic p, input logic w, input logic [15:0] a,
                          input logic [7:0] be, input logic [71:0] d);
        if (w) lg_m[a] = merge(lg_m.exists(a) ? lg_m[a] : 72'h0, d, be);
        else note(int'(p), lg_m[a]);
        if (p) u_b.access($urandom_range(2), w, a, be, d);
        else u_a.access($urandom_range(2), w, a, be, d);
    endtask

    task automatic sm_read(input logic [4:0] a, input logic [17:0] e);
        note(3, {54'h0, e});
        @(posedge sys_clk_in);
        sm_rden_in <= 1'b1;
        sm_rd_addr_in <= a;
        repeat (2) @(posedge sys_clk_in);
        sm_rden_in <= 1'b0;
        sm_rd_addr_in <= ~a;
        sm_pv <= 1'b1;
        @(posedge sys_clk_in);
        sm_pv <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #500_000;
        miscompares++;
        $display("MISMATCH watchdog expected end seen timeout");
        stop_test();
    end

    // Main sequence
    initial begin
        int k;
        logic [71:0] d, mv;
        r = $urandom(59708);
        repeat (6) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        rd(`OFS_CFG, 32'h0);
        rd(`OFS_STAT, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        wr(`OFS_CFG, 32'hFFFF_FFFF);
        rd(`OFS_CFG, 32'h0000_0FFF);
        wb(1'b1, `OFS_CFG, 32'h0, 4'h1, 1'b0);
        rd(`OFS_CFG, 32'h0000_0F00);
        // Large ports, registered then bypassed outputs
        for (int byp = 0; byp < 2; byp++) begin
            setcfg(byp ? 12'h600 : 12'h000);
            for (int i = 0; i < 4; i++) begin
                pool[i] = 16'($urandom_range(8191));
                lg_acc(i[0], 1'b1, pool[i], 8'hFF, rnd72());
                lg_acc(!i[0], 1'b0, pool[i], 8'h00, 72'h0);
            end
            for (int i = 0; i < 8; i++) begin
                k = $urandom_range(3);
                lg_acc(i[0], 1'b1, pool[k], 8'($urandom), rnd72());
                lg_acc(i[1], 1'b0, pool[k], 8'h00, 72'h0);
            end
        end
        // Same word from both large ports in one edge
        fork
            u_a.access(0, 1'b1, pool[0], 8'hFF, 72'h0AA);
            u_b.access(0, 1'b1, pool[0], 8'hFF, 72'h0BB);
        join
        lg_m[pool[0]] = 72'h0BB;
        lg_acc(1'b0, 1'b0, pool[0], 8'h00, 72'h0);
        rd(`OFS_STAT, 32'h2);
        wr(`OFS_STAT, 32'h2);
        rd(`OFS_STAT, 32'h0);
        // Clear, then port A on the second clock
        note(0, 72'h0);
        u_a.clear();
        note(1, 72'h0);
        u_b.clear();
        setcfg(12'h660);
        clk1_en_in <= 1'b0;
        note(0, 72'h0);
        u_a.access(0, 1'b0, pool[0], 8'h00, 72'h0);
        clk1_en_in <= 1'b1;
        lg_acc(1'b0, 1'b0, pool[0], 8'h00, 72'h0);
        // Medium block: bus port A against user port B
        for (int i = 0; i < 2; i++) begin
            setcfg(i ? 12'h198 : 12'h000);
            d = rnd72();
            mem_op(1'b1, 7'(i * 127), 1'b1, 4'hF, d[35:0]);
            note(2, {36'h0, d[35:0]});
            u_m.access(1, 1'b0, 7'(i * 127), 4'h0, 36'h0);
            mv = merge({36'h0, d[35:0]}, 72'hF_FFFF_FFFF, 8'h05);
            u_m.access(0, 1'b1, 7'(i * 127), 4'h5, 36'hF_FFFF_FFFF);
            mem_op(1'b1, 7'(i * 127), 1'b0, 4'h0, 36'h0);
            rd(`OFS_RLO, mv[31:0]);
            rd(`OFS_RHI, {28'h0, mv[35:32]});
        end
        setcfg(12'h800);
        u_m.access(0, 1'b1, 7'h7F, 4'hF, 36'h0);
        mem_op(1'b1, 7'h7F, 1'b0, 4'h0, 36'h0);
        rd(`OFS_RLO, mv[31:0]);
        // Small block written over the bus, read on its own port
        for (int i = 0; i < 2; i++) begin
            setcfg(i ? 12'h007 : 12'h000);
            d = rnd72();
            mem_op(1'b0, 7'(i * 31), 1'b1, 4'h3, {18'h0, d[17:0]});
            sm_read(5'(i * 31), d[17:0]);
        end
        repeat (4) @(posedge sys_clk_in);
        stop_test();
    end
endmodule
